// file: tb/edg_periph.sv
// peripheral model raising the external request
`timescale 1ns/1ps
`default_nettype none
module edg_periph (
	input wire logic clk,
	input wire logic go,
	input wire logic hold,
	input wire logic ext_grant_n,
	output logic ext_req
);
	initial ext_req = 1'b0;
	// hold keeps the line up past the grant to force another burst on purpose
	always @(negedge clk) begin
		if (go && ext_grant_n)
			ext_req <= 1'b1;
		else if (!ext_grant_n && !hold)
			ext_req <= 1'b0;
	end
endmodule : edg_periph
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the external dma request and grant block
`timescale 1ns/1ps
`default_nettype none
module testbench import edg_pkg::*; ;
	logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, hold = 1'b0, burst_done = 1'b0;
	logic ext_req, ext_grant_n, burst_start, burst_busy;
	logic [1:0] burst_channel;
	logic [3:0] sel [EDG_NCH] = '{4'h0, EDG_SRC_EXT, 4'h0, 4'h0};
	logic [3:0] req_en = 4'hF, chan_en = 4'hF, int_req = 4'h0;
	int n_errors = 0, checks_done = 0;
	initial forever #50 clk = ~clk;
	edg_ctrl u_edg_ctrl (.clk(clk), .rst_n(rst_n), .ext_req(ext_req), .ext_channel(2'h1),
		.request_source_select(sel), .request_enable(req_en), .channel_active_enable(chan_en),
		.int_req(int_req), .burst_done(burst_done), .ext_grant_n(ext_grant_n),
		.burst_start(burst_start), .burst_channel(burst_channel), .burst_busy(burst_busy));
	edg_periph u_edg_periph (.clk(clk), .go(go), .hold(hold), .ext_grant_n(ext_grant_n),
		.ext_req(ext_req));
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic wait_busy();
		for (int i = 0; i < 12 && burst_busy !== 1'b1; i++) @(negedge clk);
	endtask : wait_busy
	// done stays a level because early pulses are ignored during the minimum grant
	task automatic end_burst();
		burst_done = 1'b1;
		for (int i = 0; i < 12 && burst_busy !== 1'b0; i++) @(negedge clk);
		burst_done = 1'b0;
		chk(ext_grant_n, 4'h1);
	endtask : end_burst
	task automatic ext_burst();
		wait_busy();
		go = 1'b0;
		chk(burst_channel, 4'h1);
		chk(burst_start, 4'h1);
		repeat (7) begin
			chk(ext_grant_n, 4'h0);
			@(negedge clk);
		end
		end_burst();
	endtask : ext_burst
	task automatic test_single();
		go = 1'b1;
		ext_burst();
		repeat (4) @(negedge clk);
		chk(burst_busy, 4'h0);
	endtask : test_single
	task automatic test_enable();
		req_en[1] = 1'b0;
		go = 1'b1;
		repeat (10) @(negedge clk);
		chk(ext_grant_n, 4'h1);
		req_en[1] = 1'b1;
		chan_en[1] = 1'b0;
		repeat (10) @(negedge clk);
		chk(ext_grant_n, 4'h1);
		chan_en[1] = 1'b1;
		sel[1] = 4'h0;
		repeat (10) @(negedge clk);
		chk(ext_grant_n, 4'h1);
		sel[1] = EDG_SRC_EXT;
		ext_burst();
	endtask : test_enable
	task automatic test_priority();
		int_req[0] = 1'b1;
		go = 1'b1;
		wait_busy();
		chk(burst_channel, 4'h0);
		chk(ext_grant_n, 4'h1);
		int_req[0] = 1'b0;
		end_burst();
		ext_burst();
	endtask : test_priority
	task automatic test_demote();
		hold = 1'b1;
		go = 1'b1;
		wait_busy();
		chk(burst_channel, 4'h1);
		int_req[2] = 1'b1;
		end_burst();
		wait_busy();
		chk(burst_channel, 4'h2);
		int_req[2] = 1'b0;
		end_burst();
		hold = 1'b0;
		ext_burst();
	endtask : test_demote
	initial begin
		repeat (8) @(negedge clk);
		chk(ext_grant_n, 4'h1);
		rst_n = 1'b1;
		test_single();
		test_enable();
		test_priority();
		test_demote();
		stop_test();
	end
	initial begin
		#300000;
		n_errors++;
		stop_test();
	end
endmodule : testbench
`default_nettype wire

// file: verilog/edg_ctrl.sv
// external dma request arbitration and active low grant control
`timescale 1ns/1ps
`default_nettype none
module edg_ctrl
	import edg_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ext_req,
	input wire logic [1:0] ext_channel,
	input wire logic [3:0] request_source_select [EDG_NCH],
	input wire logic [EDG_NCH-1:0] request_enable,
	input wire logic [EDG_NCH-1:0] channel_active_enable,
	input wire logic [EDG_NCH-1:0] int_req,
	input wire logic burst_done,
	output logic ext_grant_n,
	output logic burst_start,
	output logic [1:0] burst_channel,
	output logic burst_busy
);
	typedef struct packed {
		edg_state_t state;
		logic [1:0] chan;
		logic ext;
		logic grant;
		logic [3:0] cnt;
		logic lowpri;
		logic start;
	} edg_st_t;
	edg_st_t st_r, st_nxt;
	logic req_s;
	logic [EDG_NCH-1:0] pend;
	logic [EDG_NCH-1:0] ext_ok;
	logic [1:0] win;
	logic win_v;

	// lowest index first; the external channel is pushed last when demoted
	function automatic logic [2:0] pick(input logic [EDG_NCH-1:0] p, input logic [1:0] skip,
			input logic demote);
		logic [2:0] r;
		r = 3'h0;
		for (int i = EDG_NCH - 1; i >= 0; i--) begin
			if (p[i] && !(demote && 2'(i) == skip)) begin
				r = {1'b1, 2'(i)};
			end
		end
		if (!r[2] && p[skip]) begin
			r = {1'b1, skip};
		end
		return r;
	endfunction : pick

	// any pending channel besides the external one
	function automatic logic others_pend(input logic [EDG_NCH-1:0] p, input logic [1:0] ext);
		return (p & ~(4'h1 << ext)) != 4'h0;
	endfunction : others_pend

	edg_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(ext_req),
		.q(req_s)
	);

	always_comb begin
		for (int i = 0; i < EDG_NCH; i++) begin
			ext_ok[i] = request_source_select[i] == EDG_SRC_EXT && request_enable[i]
				&& channel_active_enable[i];
			pend[i] = channel_active_enable[i] && request_enable[i]
				&& (int_req[i] || (ext_ok[i] && 2'(i) == ext_channel && req_s));
		end
		{win_v, win} = pick(pend, ext_channel, st_r.lowpri);
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.start = 1'b0;
		case (st_r.state)
			EDG_IDLE: begin
				if (win_v) begin
					st_nxt.state = EDG_BURST;
					st_nxt.chan = win;
					st_nxt.start = 1'b1;
					st_nxt.ext = ext_ok[win] && win == ext_channel && req_s;
					st_nxt.grant = st_nxt.ext;
					st_nxt.cnt = EDG_CNT_RST;
					st_nxt.lowpri = 1'b0;
				end
			end
			EDG_BURST: begin
				// request is not looked at here; grant is held to the minimum
				if (st_r.cnt != 4'hF) begin
					st_nxt.cnt = st_r.cnt + 4'h1;
				end
				// compare without adding so a saturated count cannot wrap
				if (burst_done && st_r.cnt >= EDG_GRANT_MIN_CNT - 4'h1) begin
					st_nxt.state = EDG_IDLE;
					st_nxt.grant = 1'b0;
					// demote only if someone else is waiting
					st_nxt.lowpri = st_r.ext && others_pend(pend, ext_channel);
					st_nxt.ext = 1'b0;
				end
			end
			default: begin
				st_nxt.state = EDG_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{state: EDG_IDLE, chan: EDG_IDX_RST, cnt: EDG_CNT_RST, default: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ext_grant_n = !st_r.grant;
	assign burst_start = st_r.start;
	assign burst_channel = st_r.chan;
	assign burst_busy = st_r.state == EDG_BURST;

	// burst ends only after the grant has stood its minimum
	AST_GRANT_MIN: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(ext_grant_n) |-> !ext_grant_n [*8])
		else $error("grant shorter than minimum");
	AST_GRANT_LOW: assert property (@(posedge clk) disable iff (!rst_n)
		!ext_grant_n |-> burst_busy)
		else $error("grant outside a burst");
	AST_GRANT_EXT: assert property (@(posedge clk) disable iff (!rst_n)
		burst_start |-> (ext_grant_n == !st_r.ext))
		else $error("grant does not match external burst");
	AST_START_ONE: assert property (@(posedge clk) disable iff (!rst_n)
		burst_start |=> !burst_start && burst_busy)
		else $error("burst start not single");
	AST_NO_SAMPLE: assert property (@(posedge clk) disable iff (!rst_n)
		(burst_busy && !burst_done) |=> $stable(burst_channel))
		else $error("channel changed inside burst");
	AST_REARB: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r.state == EDG_IDLE && win_v) |=> burst_start)
		else $error("pending request not started");
	AST_COND: assert property (@(posedge clk) disable iff (!rst_n)
		(burst_start && !ext_grant_n) |-> ext_ok[burst_channel])
		else $error("grant without enables");
	AST_LOWPRI: assert property (@(posedge clk) disable iff (!rst_n)
		(st_r.lowpri && win_v && others_pend(pend, ext_channel))
		|-> win != ext_channel)
		else $error("demoted channel won");
	AST_ARB: assert property (@(posedge clk) disable iff (!rst_n)
		burst_start |-> ($past(pend) & (4'h1 << burst_channel)) != 4'h0)
		else $error("burst without pending channel");

	// named steps of one burst, used by the properties below
	sequence s_arb;
		st_r.state == EDG_IDLE && win_v;
	endsequence
	sequence s_begin;
		burst_start && burst_busy;
	endsequence
	sequence s_hold8;
		burst_busy [*8];
	endsequence
	sequence s_ext_begin;
		burst_start && !ext_grant_n;
	endsequence
	sequence s_grant8;
		!ext_grant_n [*8];
	endsequence

	AST_ARB_BEGIN: assert property (@(posedge clk) disable iff (!rst_n)
		s_arb |=> s_begin)
		else $error("arbitration winner did not begin");
	AST_BUSY_MIN: assert property (@(posedge clk) disable iff (!rst_n)
		burst_start |-> s_hold8)
		else $error("burst shorter than minimum");
	AST_EXT_GRANT8: assert property (@(posedge clk) disable iff (!rst_n)
		s_ext_begin |-> s_grant8)
		else $error("external grant shorter than minimum");
	AST_GAP: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(burst_busy) |-> !burst_start)
		else $error("no idle cycle between bursts");
	AST_END_DONE: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(burst_busy) |-> $past(burst_done))
		else $error("burst ended without completion");
	AST_GRANT_FALL: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(ext_grant_n) |-> burst_start)
		else $error("grant asserted outside burst start");
	AST_GRANT_RISE: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(ext_grant_n) |-> !burst_busy)
		else $error("grant released inside a burst");
	AST_IDLE_GRANT: assert property (@(posedge clk) disable iff (!rst_n)
		!burst_busy |-> ext_grant_n)
		else $error("grant active while idle");
	AST_CHAN_SEL: assert property (@(posedge clk) disable iff (!rst_n)
		s_ext_begin |-> burst_channel == ext_channel)
		else $error("grant on a non external channel");
	AST_REQ_EXT: assert property (@(posedge clk) disable iff (!rst_n)
		s_ext_begin |-> $past(req_s))
		else $error("grant without external request");
	// a done held past a saturated count must still end the burst
	AST_CNT_SAT: assert property (@(posedge clk) disable iff (!rst_n)
		(burst_busy && burst_done && st_r.cnt == 4'hF) |=> !burst_busy)
		else $error("burst stuck at saturated count");
	AST_CNT_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
		burst_start |-> st_r.cnt == EDG_CNT_RST)
		else $error("burst count not cleared");
	AST_CNT_STEP: assert property (@(posedge clk) disable iff (!rst_n)
		(burst_busy && st_r.cnt != 4'hF) |=> (!burst_busy || st_r.cnt == $past(st_r.cnt) + 4'h1))
		else $error("burst count skipped a cycle");
	AST_START_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
		burst_start |-> $past(!burst_busy))
		else $error("burst began without idle cycle");
	AST_DEMOTE_CLR: assert property (@(posedge clk) disable iff (!rst_n)
		burst_start |-> !st_r.lowpri)
		else $error("demotion outlived one arbitration");
	AST_LOWPRI_SET: assert property (@(posedge clk) disable iff (!rst_n)
		(burst_busy && !ext_grant_n && burst_done && st_r.cnt >= EDG_GRANT_MIN_CNT - 4'h1
		&& others_pend(pend, ext_channel)) |=> st_r.lowpri)
		else $error("external channel not demoted");
endmodule : edg_ctrl
`default_nettype wire

// file: verilog/edg_pkg.sv
// constants and types for the external dma request and grant block
// Operation
// - grant asserted only when the external channel wins priority arbitration
// - each recognised request yields one or more complete bursts
// - grant output is active low
// - grant active only during a burst for an external request
// - grant needs source select external, both enables set, request asserted
// - request not sampled while grant is active, resumes after burst
// - after service, external channel gets low priority if others pend
// - grant held at least eight clock cycles
// - timing limits hold for the smallest one byte burst
// - all timing counts are system clock periods
package edg_pkg;
	localparam int unsigned EDG_NCH = 4;
	localparam int unsigned EDG_CLK_HZ = 10000000;
	// minimum grant time in clock periods as printed
	localparam int unsigned EDG_GRANT_MIN_HCLK = 8;
	localparam int unsigned EDG_GRANT_MIN_CYC = EDG_GRANT_MIN_HCLK < 1 ? 1 : EDG_GRANT_MIN_HCLK;
	localparam logic [3:0] EDG_GRANT_MIN_CNT = 4'(EDG_GRANT_MIN_CYC);
	localparam logic [3:0] EDG_CNT_RST = 4'h0;
	localparam logic [1:0] EDG_IDX_RST = 2'h0;
	localparam logic [3:0] EDG_SRC_EXT = 4'hF;
	typedef enum {EDG_IDLE, EDG_BURST} edg_state_t;
endpackage : edg_pkg

// file: verilog/edg_sync.sv
// two flop synchroniser for the external request pin
`timescale 1ns/1ps
`default_nettype none
module edg_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} edg_sync_st_t;
	edg_sync_st_t st_r, st_nxt;
	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q = st_r.s2;
endmodule : edg_sync
`default_nettype wire
